// ### rtl/modbus_fn_handler.sv
// modbus rtu slave handler for diagnostic echo, write-multiple and access log
// How it works
// - diagnostic subfunction zero echoes any two-byte data value
// - diagnostic and write-multiple responses repeat the first six bytes and crc
// - broadcast queries are carried out but never answered
// - write-multiple field order: addr, func, start, count, bytes, data, crc
// - write-multiple to address zero is a broadcast write without reply
// - transmitted start address is holding register number minus 40001
// - at most 125 registers per write-multiple query
// - byte count equals twice register count, within 2 to 250
// - write words high byte first, ascending register order
// - access-log function reports on the last read or write-multiple query
// - log holds start address and count of successfully accessed registers
// - any other previous function leaves zero address and zero count
// - illegal function, address or data gives exception reply func plus 80
// - parity, crc, overrun, framing or busy errors get no reply
// - frames shorter than four bytes are frame errors
module modbus_fn_handler
	import modbus_fn_pkg::*;
#(
	parameter int BUF_DEPTH = 260
) (
	input  wire logic       sys_clk_i,    // system clock
	input  wire logic       resetn_i,     // async reset, active low
	input  wire logic [7:0] slave_addr_i, // own station address
	input  wire byte_strm_t rx_i,         // received byte strobe
	input  wire logic       rx_err_i,     // parity, framing or overrun pulse
	input  wire logic       frame_end_i,  // end-of-frame silence pulse
	input  wire log_rec_t   rd_log_i,     // successful read report
	output reg_wr_t         wr_o,         // holding register write strobe
	input  wire logic       wr_ok_i,      // register accepted the write
	output byte_strm_t      tx_o,         // response byte stream
	input  wire logic       tx_ready_i,   // transmitter takes the byte
	output logic            tx_last_o,    // current byte ends the response
	output logic            busy_o        // query being processed
);

	typedef enum {S_RX, S_CHECK, S_WRITE, S_TX} state_t;

	localparam int IDXW = $clog2(BUF_DEPTH + 1);

	logic [7:0]        buf_q [BUF_DEPTH];
	state_t            state_q, state_d;
	logic [IDXW-1:0]   len_q, len_d;
	logic [15:0]       crc_q, crc_d;
	logic              bad_q, bad_d;
	logic              bcast_q, bcast_d;
	logic [6:0]        widx_q, widx_d;
	logic [15:0]       ok_cnt_q, ok_cnt_d;
	logic [15:0]       ok_start_q, ok_start_d;
	logic [15:0]       log_start_q, log_start_d;
	logic [15:0]       log_cnt_q, log_cnt_d;
	logic [5:0][7:0]   resp_q, resp_d;
	logic [3:0]        resp_len_q, resp_len_d;
	logic [3:0]        tx_idx_q, tx_idx_d;
	logic [7:0]        tx_byte_q, tx_byte_d;
	logic [15:0]       tx_crc_q, tx_crc_d;
	reg_wr_t           wr_q, wr_d;

	// decoded query fields
	logic [7:0]  q_slave, q_func, q_bc;
	logic [15:0] q_f1, q_f2, q_crc_next;
	logic [8:0]  q_len;
	logic [IDXW-1:0] d_pos;

	assign q_slave = buf_q[POS_SLAVE];
	assign q_func  = buf_q[POS_FUNC];
	assign q_f1    = {buf_q[POS_F1_HI], buf_q[POS_F1_LO]};
	assign q_f2    = {buf_q[POS_F2_HI], buf_q[POS_F2_LO]};
	assign q_bc    = buf_q[POS_BYTE_CNT];
	assign q_len   = 9'(len_q);
	assign d_pos   = IDXW'(POS_DATA) + IDXW'({widx_q, 1'b0});

	// frame store, written only while receiving
	always_ff @(posedge sys_clk_i) begin
		if (state_q == S_RX && rx_i.valid && len_q < IDXW'(BUF_DEPTH)) begin
			buf_q[len_q] <= rx_i.data;
		end
	end

	// next-state logic for the whole handler
	always_comb begin
		state_d     = state_q;
		len_d       = len_q;
		crc_d       = crc_q;
		bad_d       = bad_q;
		bcast_d     = bcast_q;
		widx_d      = widx_q;
		ok_cnt_d    = ok_cnt_q;
		ok_start_d  = ok_start_q;
		log_start_d = log_start_q;
		log_cnt_d   = log_cnt_q;
		resp_d      = resp_q;
		resp_len_d  = resp_len_q;
		tx_idx_d    = tx_idx_q;
		tx_byte_d   = tx_byte_q;
		tx_crc_d    = tx_crc_q;
		q_crc_next  = tx_crc_q;
		wr_d        = '0;

		// a successful read elsewhere overwrites the log
		if (rd_log_i.valid) begin
			log_start_d = rd_log_i.start;
			log_cnt_d   = rd_log_i.count;
		end

		unique case (state_q)
			S_RX: begin
				if (rx_i.valid) begin
					crc_d = crc16_step(crc_q, rx_i.data);
					if (len_q == IDXW'(BUF_DEPTH)) bad_d = 1'b1;
					else len_d = len_q + 1'b1;
				end
				if (rx_err_i) bad_d = 1'b1;
				if (frame_end_i) begin
					// short, corrupt or errored frames vanish without reply
					if (!bad_q && !rx_err_i && q_len >= MIN_FRAME_LEN && crc_q == CRC_RESIDUE) begin
						state_d = S_CHECK; // length stays for the field checks
					end else begin
						len_d = '0;
					end
					crc_d = CRC_INIT;
					bad_d = 1'b0;
				end
			end

			S_CHECK: begin
				bcast_d    = (q_slave == BCAST_ADDR);
				resp_d     = {q_f2[7:0], q_f2[15:8], q_f1[7:0], q_f1[15:8], q_func, q_slave};
				resp_len_d = RESP_LEN_FULL;
				state_d    = S_TX;
				if (q_slave != slave_addr_i && q_slave != BCAST_ADDR) begin
					state_d = S_RX;
				end else begin
					unique case (q_func)
						FN_DIAG: begin
							log_start_d = '0;
							log_cnt_d   = '0;
							if (q_slave == BCAST_ADDR) begin
								state_d = S_RX;
							end else if (q_f1 != DIAG_SUB_ECHO) begin
								resp_d[1]  = q_func | EXC_FLAG;
								resp_d[2]  = EXC_ILL_FUNC;
								resp_len_d = RESP_LEN_EXC;
							end else if (q_len != DIAG_FRAME_LEN) begin
								resp_d[1]  = q_func | EXC_FLAG;
								resp_d[2]  = EXC_ILL_DATA;
								resp_len_d = RESP_LEN_EXC;
							end
						end
						FN_WRITE_MULTI: begin
							// count, byte count and frame length must all agree
							if (q_f2 == '0 || q_f2 > MAX_WRITE_REGS
								|| q_bc < BYTE_CNT_MIN || q_bc > BYTE_CNT_MAX
								|| {q_f2[7:0], 1'b0} != {1'b0, q_bc}
								|| q_len != WRM_HDR_LEN + {1'b0, q_bc}) begin
								log_start_d = '0;
								log_cnt_d   = '0;
								resp_d[1]   = q_func | EXC_FLAG;
								resp_d[2]   = EXC_ILL_DATA;
								resp_len_d  = RESP_LEN_EXC;
							end else begin
								state_d    = S_WRITE;
								widx_d     = '0;
								ok_cnt_d   = '0;
								ok_start_d = '0;
							end
						end
						FN_ACCESS_LOG: begin
							if (q_slave == BCAST_ADDR || q_len != LOG_FRAME_LEN) begin
								state_d = S_RX;
							end else begin
								resp_d[5:2] = {log_cnt_q[7:0], log_cnt_q[15:8],
								               log_start_q[7:0], log_start_q[15:8]};
							end
							log_start_d = '0;
							log_cnt_d   = '0;
						end
						FN_READ: state_d = S_RX; // read path reports through rd_log_i
						FN_WRITE_ONE: begin
							state_d     = S_RX;
							log_start_d = '0;
							log_cnt_d   = '0;
						end
						default: begin
							log_start_d = '0;
							log_cnt_d   = '0;
							resp_d[1]   = q_func | EXC_FLAG;
							resp_d[2]   = EXC_ILL_FUNC;
							resp_len_d  = RESP_LEN_EXC;
						end
					endcase
				end
				// broadcasts never answer, even with an exception
				if (q_slave == BCAST_ADDR && state_d == S_TX) state_d = S_RX;
			end

			S_WRITE: begin
				// one register every second cycle, start address upward
				wr_d.valid = 1'b1;
				wr_d.addr  = q_f1 + 16'(widx_q);
				wr_d.data  = {buf_q[d_pos], buf_q[d_pos + 1'b1]};
				if (wr_q.valid) begin
					wr_d.valid = 1'b0;
					if (wr_ok_i) begin
						ok_cnt_d = ok_cnt_q + 1'b1;
						if (ok_cnt_q == '0) ok_start_d = wr_q.addr;
					end
					widx_d = widx_q + 1'b1;
					if (16'(widx_q) + 16'h0001 == q_f2) begin
						log_start_d = wr_ok_i && ok_cnt_q == '0 ? wr_q.addr : ok_start_q;
						log_cnt_d   = ok_cnt_d;
						state_d     = bcast_q ? S_RX : S_TX;
						if (ok_cnt_d == '0) begin
							resp_d[1]  = q_func | EXC_FLAG;
							resp_d[2]  = EXC_ILL_ADDR;
							resp_len_d = RESP_LEN_EXC;
						end
					end
				end
			end

			S_TX: begin
				if (tx_ready_i) begin
					tx_idx_d = tx_idx_q + 1'b1;
					if (tx_idx_q < resp_len_q) begin
						q_crc_next = crc16_step(tx_crc_q, tx_byte_q);
						tx_crc_d   = q_crc_next;
					end
					if (tx_idx_q + 1'b1 < resp_len_q) tx_byte_d = resp_q[3'(tx_idx_q + 1'b1)];
					else if (tx_idx_q + 1'b1 == resp_len_q) tx_byte_d = q_crc_next[7:0];
					else tx_byte_d = tx_crc_q[15:8];
					if (tx_last_o) state_d = S_RX;
				end
			end
		endcase

		// prime the transmitter on entry
		if (state_q != S_TX && state_d == S_TX) begin
			tx_idx_d  = '0;
			tx_crc_d  = CRC_INIT;
			tx_byte_d = resp_d[0];
		end
		// back to idle clears the frame length; bytes arriving while busy spoil that frame
		if (state_q != S_RX) begin
			if (state_d == S_RX) len_d = '0;
			if (rx_i.valid || rx_err_i) bad_d = 1'b1;
			else if (frame_end_i) bad_d = 1'b0;
		end
	end

	// register all handler state except the frame store, which is written in its own block
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q     <= S_RX;
			len_q       <= '0;
			crc_q       <= CRC_INIT;
			bad_q       <= 1'b0;
			bcast_q     <= 1'b0;
			widx_q      <= '0;
			ok_cnt_q    <= '0;
			ok_start_q  <= '0;
			log_start_q <= '0;
			log_cnt_q   <= '0;
			resp_q      <= '0;
			resp_len_q  <= '0;
			tx_idx_q    <= '0;
			tx_byte_q   <= '0;
			tx_crc_q    <= CRC_INIT;
			wr_q        <= '0;
		end else begin
			state_q     <= state_d;
			len_q       <= len_d;
			crc_q       <= crc_d;
			bad_q       <= bad_d;
			bcast_q     <= bcast_d;
			widx_q      <= widx_d;
			ok_cnt_q    <= ok_cnt_d;
			ok_start_q  <= ok_start_d;
			log_start_q <= log_start_d;
			log_cnt_q   <= log_cnt_d;
			resp_q      <= resp_d;
			resp_len_q  <= resp_len_d;
			tx_idx_q    <= tx_idx_d;
			tx_byte_q   <= tx_byte_d;
			tx_crc_q    <= tx_crc_d;
			wr_q        <= wr_d;
		end
	end

	// outputs
	assign wr_o       = wr_q;
	assign tx_o.valid = (state_q == S_TX);
	assign tx_o.data  = tx_byte_q;
	assign tx_last_o  = (state_q == S_TX) && (tx_idx_q == resp_len_q + 1'b1);
	assign busy_o     = (state_q != S_RX);
endmodule

// ### rtl/modbus_fn_pkg.sv
// shared constants, types and crc helper for the modbus function handler
package modbus_fn_pkg;

	// function codes, exception codes and special addresses
	localparam logic [7:0]  FN_READ         = 8'h03;
	localparam logic [7:0]  FN_WRITE_ONE    = 8'h06;
	localparam logic [7:0]  FN_DIAG         = 8'h08;
	localparam logic [7:0]  FN_WRITE_MULTI  = 8'h10;
	localparam logic [7:0]  FN_ACCESS_LOG   = 8'h46;
	localparam logic [7:0]  EXC_FLAG        = 8'h80;
	localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
	localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
	localparam logic [7:0]  EXC_ILL_DATA    = 8'h03;
	localparam logic [7:0]  BCAST_ADDR      = 8'h00;
	localparam logic [15:0] DIAG_SUB_ECHO   = 16'h0000;

	// write-multiple field limits
	localparam logic [15:0] MAX_WRITE_REGS  = 16'h007d;
	localparam logic [7:0]  BYTE_CNT_MIN    = 8'h02;
	localparam logic [7:0]  BYTE_CNT_MAX    = 8'hfa;
	localparam int          HOLD_REG_BASE   = 40001;

	// byte positions inside a received frame
	localparam int          POS_SLAVE       = 0;
	localparam int          POS_FUNC        = 1;
	localparam int          POS_F1_HI       = 2;
	localparam int          POS_F1_LO       = 3;
	localparam int          POS_F2_HI       = 4;
	localparam int          POS_F2_LO       = 5;
	localparam int          POS_BYTE_CNT    = 6;
	localparam int          POS_DATA        = 7;

	// frame lengths including the two crc bytes, response lengths without them
	localparam logic [8:0]  MIN_FRAME_LEN   = 9'h004;
	localparam logic [8:0]  DIAG_FRAME_LEN  = 9'h008;
	localparam logic [8:0]  LOG_FRAME_LEN   = 9'h004;
	localparam logic [8:0]  WRM_HDR_LEN     = 9'h009;
	localparam logic [3:0]  RESP_LEN_FULL   = 4'h6;
	localparam logic [3:0]  RESP_LEN_EXC    = 4'h3;

	// crc-16 as used on rtu links, reflected polynomial
	localparam logic [15:0] CRC_INIT        = 16'hffff;
	localparam logic [15:0] CRC_POLY        = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE     = 16'h0000;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} byte_strm_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
	} reg_wr_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] start;
		logic [15:0] count;
	} log_rec_t;

	// fold one byte into the running crc
	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

endpackage

// ### verif/modbus_fn_handler_monitor.sv
// port checks for the modbus function handler
module modbus_fn_handler_monitor
	import modbus_fn_pkg::*;
(
	input wire logic       sys_clk_i,    // clock
	input wire logic       resetn_i,     // reset, active low
	input wire logic [7:0] slave_addr_i, // own address
	input wire logic       frame_end_i,  // frame close pulse
	input wire reg_wr_t    wr_o,         // write strobe
	input wire byte_strm_t tx_o,         // response stream
	input wire logic       tx_ready_i,   // response taken
	input wire logic       tx_last_o,    // last byte flag
	input wire logic       busy_o        // processing
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [3:0] n_q;

	// bytes handed over in the current response
	always_ff @(posedge sys_clk_i or negedge resetn_i)
		if (!resetn_i) n_q <= 4'h0;
		else if (tx_o.valid && tx_ready_i) n_q <= tx_last_o ? 4'h0 : n_q + 4'h1;

	property p_accept; $rose(busy_o) |-> $past(frame_end_i); endproperty
	a_accept: assert property (p_accept) else $error("busy rose without frame end");
	property p_first; $rose(tx_o.valid) |-> tx_o.data == slave_addr_i && !tx_last_o; endproperty
	a_first: assert property (p_first) else $error("reply does not open with own address");
	property p_hold; tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data) && $stable(tx_last_o); endproperty
	a_hold: assert property (p_hold) else $error("reply byte changed before taken");
	property p_end; tx_last_o && tx_ready_i |=> !tx_o.valid && !busy_o; endproperty
	a_end: assert property (p_end) else $error("reply not closed after last byte");
	property p_len; tx_last_o && tx_ready_i |-> n_q == 4'h7 || n_q == 4'h4; endproperty
	a_len: assert property (p_len) else $error("reply length wrong");
	property p_gap; wr_o.valid |=> !wr_o.valid; endproperty
	a_gap: assert property (p_gap) else $error("writes back to back");
	property p_step; wr_o.valid ##2 wr_o.valid |-> wr_o.addr == $past(wr_o.addr, 2) + 16'h1; endproperty
	a_step: assert property (p_step) else $error("write address not ascending");
	property p_wr_tx; wr_o.valid |-> busy_o && !tx_o.valid; endproperty
	a_wr_tx: assert property (p_wr_tx) else $error("write outside processing");
	property p_bound; $rose(busy_o) |-> ##[1:1000] !busy_o; endproperty
	a_bound: assert property (p_bound) else $error("processing does not finish");
endmodule

bind modbus_fn_handler modbus_fn_handler_monitor u_mon (.sys_clk_i, .resetn_i, .slave_addr_i, .frame_end_i,
	.wr_o, .tx_o, .tx_ready_i, .tx_last_o, .busy_o);

// ### verif/modbus_master_model.sv
// behavioural rtu master: sends queries and gathers replies
module modbus_master_model
	import modbus_fn_pkg::*;
(
	input  wire logic       clk_i,       // system clock
	output byte_strm_t      rx_o,        // query bytes
	output logic            err_o,       // line error pulse
	output logic            frame_end_o, // frame close pulse
	input  wire byte_strm_t tx_i,        // reply bytes
	input  wire logic       tx_last_i,   // last reply byte
	output logic            tx_ready_o   // reply taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] qb[$];
	logic [7:0] rb[$];

	// idle levels from time zero
	initial begin
		rx_o = '0;
		err_o = 1'b0;
		frame_end_o = 1'b0;
		tx_ready_o = 1'b0;
	end

	// reflected crc-16 of a byte queue
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction

	// send qb with crc, then collect a reply into rb
	task automatic xfer(input bit good, input bit slow, input bit err);
		logic [15:0] c;
		c = crc(qb) ^ {!good, 15'h0000};
		qb.push_back(c[7:0]);
		qb.push_back(c[15:8]);
		rb.delete();
		foreach (qb[i]) begin
			@(negedge clk_i);
			rx_o = '{1'b1, qb[i]};
			err_o = err && i == 0;
		end
		@(negedge clk_i);
		rx_o = '{1'b0, ~qb[qb.size() - 1]};
		err_o = 1'b0;
		frame_end_o = 1'b1;
		@(negedge clk_i);
		frame_end_o = 1'b0;
		// bounded wait also covers the pause after a broadcast
		for (int k = 0; k < 700; k++) begin
			@(negedge clk_i);
			tx_ready_o = !slow || k[0];
			if (tx_i.valid && tx_ready_o) begin
				rb.push_back(tx_i.data);
				if (tx_last_i) break;
			end
		end
		@(negedge clk_i);
		tx_ready_o = 1'b0;
	endtask
endmodule

// ### verif/modbus_fn_handler_tb.sv
// self-checking bench for the modbus function handler
module modbus_fn_handler_tb;
	import modbus_fn_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 1'b0;
	logic        resetn  = 1'b0;
	byte_strm_t  rx;
	byte_strm_t  tx;
	reg_wr_t     wr;
	log_rec_t    rd_log  = '0;
	logic        rx_err;
	logic        frame_end;
	logic        tx_ready;
	logic        tx_last;
	logic        busy;
	logic [15:0] rej     = 16'hffff;
	logic [31:0] wq[$];
	int          fail_count = 0;
	int          total_checks = 0;
	wire logic   wr_ok   = wr.valid && wr.addr !== rej;

	always #25 sys_clk = ~sys_clk;

	// record every register write
	always @(negedge sys_clk) if (wr.valid) wq.push_back({wr.addr, wr.data});

	modbus_fn_handler DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .slave_addr_i(8'h19), .rx_i(rx),
		.rx_err_i(rx_err), .frame_end_i(frame_end), .rd_log_i(rd_log), .wr_o(wr), .wr_ok_i(wr_ok),
		.tx_o(tx), .tx_ready_i(tx_ready), .tx_last_o(tx_last), .busy_o(busy));
	modbus_master_model M (.clk_i(sys_clk), .rx_o(rx), .err_o(rx_err), .frame_end_o(frame_end),
		.tx_i(tx), .tx_last_i(tx_last), .tx_ready_o(tx_ready));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	// compare the reply with e plus its crc
	task automatic rsp(input logic [7:0] e[$]);
		logic [15:0] c;
		c = M.crc(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		chk("rsp_len", e.size(), M.rb.size());
		foreach (e[i]) if (i < M.rb.size()) chk("rsp_byte", e[i], M.rb[i]);
	endtask

	// one query through the master, then the handler must be idle again
	task automatic send(input bit good, input bit slow, input bit err);
		M.xfer(good, slow, err);
		chk("idle", 1'b0, busy);
	endtask

	task automatic log_q(input logic [15:0] s, input logic [15:0] n);
		M.qb = '{8'h19, FN_ACCESS_LOG};
		send(1, 1, 0);
		rsp('{8'h19, FN_ACCESS_LOG, s[15:8], s[7:0], n[15:8], n[7:0]});
	endtask

	// echo at both data extremes, log zero after it, no echo to broadcast
	task automatic t_diag();
		for (int i = 0; i < 2; i++) begin
			M.qb = '{8'h19, FN_DIAG, 8'h00, 8'h00, {8{i[0]}}, {8{i[0]}}};
			send(1, i, 0);
			chk("echo_len", 8, M.rb.size());
			foreach (M.rb[j]) chk("echo", M.qb[j], M.rb[j]);
		end
		log_q(16'h0000, 16'h0000);
		M.qb = '{BCAST_ADDR, FN_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
		send(1, 0, 0);
		chk("diag_bcast", 0, M.rb.size());
	endtask

	// multi write: order, data, reply, log; first register may refuse
	task automatic t_write(input logic [7:0] sa, input int n, input logic [15:0] st, input bit rj);
		logic [7:0] q[$];
		q = '{sa, FN_WRITE_MULTI, st[15:8], st[7:0], 8'h00, 8'(n), 8'(2 * n)};
		for (int i = 0; i < n; i++) begin
			q.push_back(8'(i));
			q.push_back(8'(i + 64));
		end
		rej = rj ? st : 16'hffff;
		wq.delete();
		M.qb = q;
		send(1, 0, 0);
		chk("writes", n, wq.size());
		foreach (wq[i]) chk("wr", {st + 16'(i), 8'(i), 8'(i + 64)}, wq[i]);
		if (sa == BCAST_ADDR) chk("bcast_rsp", 0, M.rb.size());
		else begin
			rsp(q[0:5]);
			log_q(st + 16'(rj), 16'(n - rj));
		end
	endtask

	// unknown function, bad subfunction, too many registers
	task automatic t_exc();
		logic [7:0] q[$];
		for (int i = 0; i < 3; i++) begin
			case (i)
				0: q = '{8'h19, 8'h2b};
				1: q = '{8'h19, FN_DIAG, 8'h00, 8'h01, 8'h00, 8'h00};
				default: q = '{8'h19, FN_WRITE_MULTI, 8'h00, 8'h00, 8'h00, 8'h7e, 8'hfc, 8'h00, 8'h00};
			endcase
			M.qb = q;
			send(1, 0, 0);
			rsp('{8'h19, q[1] | EXC_FLAG, i < 2 ? EXC_ILL_FUNC : EXC_ILL_DATA});
		end
	endtask

	// bad crc, line error, runt frame and foreign address stay unanswered
	task automatic t_drop();
		for (int i = 0; i < 4; i++) begin
			M.qb = '{8'h19, FN_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
			if (i == 2) M.qb = '{8'h19};
			if (i == 3) M.qb[0] = 8'h1a;
			send(i != 0, 0, i == 1);
			chk("drop", 0, M.rb.size());
		end
	endtask

	// read path report is returned by the log query
	task automatic t_rdlog();
		@(negedge sys_clk);
		rd_log = '{1'b1, 16'h03ea, 16'h0003};
		@(negedge sys_clk);
		rd_log.valid = 1'b0;
		log_q(16'h03ea, 16'h0003);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (90000) @(posedge sys_clk);
		fail_count++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		t_diag();
		t_write(8'h19, 3, 16'(41007 - HOLD_REG_BASE), 1);
		t_write(8'h19, 125, 16'h0000, 0);
		t_write(BCAST_ADDR, 1, 16'h0005, 0);
		t_exc();
		t_drop();
		t_rdlog();
		conclude();
	end
endmodule
